// ==== dv/flash_single_word_program_tb.sv ====
`timescale 1ns/1ps
module flash_single_word_program_tb;
  import fwp_pkg::*;
  typedef struct packed
  {
    logic we;
    logic [5:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } fwp_row_s;
  // short write time keeps the run brief
  localparam int WC = 20;
  logic ref_clk, reset_n, cyc, stb, we, ack, err, fwr, stall, e;
  logic [5:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat, q;
  logic [20:0] faddr, cap_a;
  logic [15:0] fdata, cap_d;
  int bad_count = 0;
  int samples_checked = 0;
  int wr_cnt = 0;
  int st_cnt = 0;
  fwp_row_s rows[8] = '{
    '{1'b0, 6'h00, 32'h0, 32'h0, 1'b0}, '{1'b1, 6'h14, 32'hffff, 32'h0, 1'b0},
    '{1'b0, 6'h14, 32'h0, 32'h0, 1'b0}, '{1'b1, 6'h08, 32'h1ffffe, 32'h0, 1'b0},
    '{1'b0, 6'h08, 32'h0, 32'h1ffffe, 1'b0}, '{1'b1, 6'h0c, 32'ha5, 32'h0, 1'b0},
    '{1'b0, 6'h0c, 32'h0, 32'ha5, 1'b0}, '{1'b0, 6'h1c, 32'h0, 32'h0, 1'b1}};

  fwp_flash_word_prog #(.WRITE_CYC(WC)) fwp_flash_word_prog_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .flash_wr_o(fwr),
    .flash_addr_o(faddr), .flash_data_o(fdata), .cpu_stall_o(stall));

  task automatic end_of_test;
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  // request held until ack or err is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do
    begin
      @(posedge ref_clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // launch pulses and stall cycles counted as they happen
  always @(posedge ref_clk)
  begin
    if (fwr === 1'b1)
    begin
      wr_cnt++;
      cap_a = faddr;
      cap_d = fdata;
    end
    if (stall === 1'b1)
      st_cnt++;
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    end_of_test;
  end

  initial
  begin
    {reset_n, cyc, stb, we, adr, sel, dat} <= '0;
    repeat (8) @(posedge ref_clk);
    chk(32'({ack, err, fwr, stall}), 32'h0);
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i])
    begin
      bus(rows[i].we, rows[i].a, rows[i].d);
      chk(32'(e), 32'(rows[i].e));
      if (!rows[i].we)
        chk(q, rows[i].x);
    end
    // low byte at even address with post-increment, then high byte
    wr(6'h08, 32'h12344);
    wr(6'h0c, 32'h34);
    wr(6'h10, 32'h1);
    wr(6'h0c, 32'h12);
    wr(6'h10, 32'h0);
    bus(1'b0, 6'h14, 32'h0);
    chk(q, 32'h1234);
    // starts without key, without write enable, or with a broken key
    wr(6'h00, 32'h26);
    wr(6'h04, 32'h55);
    wr(6'h04, 32'haa);
    wr(6'h00, 32'h22);
    wr(6'h04, 32'h55);
    wr(6'h08, 32'h12344);
    wr(6'h04, 32'haa);
    wr(6'h00, 32'h26);
    chk(wr_cnt, 32'h0);
    wr(6'h00, 32'h24);
    wr(6'h04, 32'h55);
    wr(6'h04, 32'haa);
    wr(6'h00, 32'h26);
    // status shows busy, and writes are shut out while stalled
    bus(1'b0, 6'h18, 32'h0);
    chk(q, 32'h1);
    wr(6'h0c, 32'hff);
    repeat (WC + 10) @(posedge ref_clk);
    chk(wr_cnt, 32'h1);
    chk(st_cnt, WC);
    chk(32'(cap_a), 32'h12344);
    chk(32'(cap_d), 32'h1234);
    bus(1'b0, 6'h00, 32'h0);
    chk(q, 32'h24);
    bus(1'b0, 6'h18, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 6'h0c, 32'h0);
    chk(q, 32'h12);
    wr(6'h00, 32'h0);
    bus(1'b0, 6'h00, 32'h0);
    chk(q, 32'h0);
    end_of_test;
  end
endmodule

// ==== rtl/fwp_flash_word_prog.sv ====
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
// Overview of operation
// R1: select plus write enable program one two-byte word per write cycle.
// R2: software only word-writes locations that are already erased.
// R3: software loads the pointer with an even target address first.
// R4: table writes fill two holding bytes; only the first may increment (the code increments on any table write with FWP_BIT_POSTINC set).
// R5: software writes the low byte at the even address, then the high byte.
// R6: software sets write enable and word-program select before the key.
// R7: a start needs 55h then 0aah written back to back to the key register.
// R8: the start bit set right after the key launches the held word.
// R9: the cpu stalls for the whole word write time, then resumes.
// R10: when done, software clears word-program select and write enable.
// R11: software masks interrupts from before the key until the stall ends.
// R12: a start without write enable or a fresh key is ignored.
module fwp_flash_word_prog
  import fwp_pkg::*;
#(
  parameter int WRITE_CYC = fwp_pkg::FWP_WORD_WRITE_CYC
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // flash array write port
  output logic flash_wr_o,
  output logic [fwp_pkg::FWP_PTR_W-1:0] flash_addr_o,
  output logic [15:0] flash_data_o,
  // cpu stall
  output logic cpu_stall_o
);

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_OPEN} fwp_key_e;

  typedef struct packed {
    logic [7:0] ctrl;
    fwp_key_e key;
    logic [FWP_PTR_W-1:0] ptr;
    logic [7:0] latch;
    logic [15:0] hold;
    logic busy;
    logic [31:0] cnt;
    logic ack;
    logic err;
    logic [31:0] rdat;
    logic fwr;
    logic [FWP_PTR_W-1:0] faddr;
  } fwp_state_s;

  fwp_state_s st_ff;
  fwp_state_s nxt_st;
  logic req;
  logic wr_lane0;

  // a bus access starts once; ack drops the cycle after it was given
  assign req = wb_cyc_i && wb_stb_i && !st_ff.ack && !st_ff.err;
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

  function automatic logic is_mapped(input logic [5:0] a);
    is_mapped = (a[5:2] <= FWP_IDX_STAT) && (a[1:0] == 2'b00);
  endfunction

  // next-state logic for the whole block
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.err = 1'b0;
    nxt_st.fwr = 1'b0;
    if (st_ff.busy)
    begin
      // stall holds for the full word write time
      if (st_ff.cnt == 32'h00000001)
      begin
        nxt_st.busy = 1'b0; // R9
        nxt_st.ctrl[FWP_BIT_START] = 1'b0;
      end
      nxt_st.cnt = st_ff.cnt - 32'h00000001;
    end
    if (req)
    begin
      nxt_st.ack = is_mapped(wb_adr_i);
      nxt_st.err = !is_mapped(wb_adr_i);
      case (wb_adr_i[5:2])
        FWP_IDX_CTRL: nxt_st.rdat = {24'h000000, st_ff.ctrl};
        FWP_IDX_PTR: nxt_st.rdat = 32'(st_ff.ptr);
        FWP_IDX_LATCH: nxt_st.rdat = {24'h000000, st_ff.latch};
        FWP_IDX_HOLD: nxt_st.rdat = {16'h0000, st_ff.hold};
        FWP_IDX_STAT: nxt_st.rdat = {31'h00000000, st_ff.busy};
        default: nxt_st.rdat = FWP_BAD_READ;
      endcase
    end
    // any byte-lane-0 write to another register breaks a key sequence in progress
    if (wr_lane0 && wb_adr_i[5:2] != FWP_IDX_KEY)
      nxt_st.key = KEY_IDLE; // R7
    if (wr_lane0 && !st_ff.busy)
    begin
      case (wb_adr_i[5:2])
        FWP_IDX_KEY:
        begin
          // 55h then aah, back to back; anything else restarts
          if (st_ff.key == KEY_IDLE && wb_dat_i[7:0] == FWP_KEY_FIRST)
            nxt_st.key = KEY_GOT1; // R7
          else if (st_ff.key == KEY_GOT1 &&
                   wb_dat_i[7:0] == FWP_KEY_SECOND)
            nxt_st.key = KEY_OPEN; // R7
          else if (wb_dat_i[7:0] == FWP_KEY_FIRST)
            nxt_st.key = KEY_GOT1;
          else
            nxt_st.key = KEY_IDLE;
        end
        FWP_IDX_CTRL:
        begin
          nxt_st.ctrl = wb_dat_i[7:0];
          nxt_st.ctrl[FWP_BIT_START] = 1'b0;
          // start only with enable, select and an open key
          if (wb_dat_i[FWP_BIT_START] && st_ff.key == KEY_OPEN &&
              wb_dat_i[FWP_BIT_WRITE_EN] && wb_dat_i[FWP_BIT_WORD_SEL]) // R12
          begin
            nxt_st.ctrl[FWP_BIT_START] = 1'b1; // R8
            nxt_st.busy = 1'b1; // R9
            nxt_st.cnt = 32'(WRITE_CYC);
            nxt_st.fwr = 1'b1; // R1
            nxt_st.faddr = {st_ff.ptr[FWP_PTR_W-1:1], 1'b0};
          end
        end
        FWP_IDX_PTR: nxt_st.ptr = wb_dat_i[FWP_PTR_W-1:0];
        FWP_IDX_LATCH: nxt_st.latch = wb_dat_i[7:0];
        FWP_IDX_TBLWR:
        begin
          // byte lane picked by pointer bit 0: low byte at even address
          if (st_ff.ptr[0])
            nxt_st.hold[15:8] = st_ff.latch; // R4
          else
            nxt_st.hold[7:0] = st_ff.latch; // R4
          if (wb_dat_i[FWP_BIT_POSTINC])
            nxt_st.ptr = st_ff.ptr + FWP_PTR_W'(1);
        end
        default: nxt_st.key = KEY_IDLE;
      endcase
    end
    // a key left open is spent by the next control write
    if (wr_lane0 && wb_adr_i[5:2] == FWP_IDX_CTRL)
      nxt_st.key = KEY_IDLE; // R12
  end

  // single state register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
      st_ff.ctrl <= FWP_CTRL_RST;
      st_ff.key <= KEY_IDLE;
    end
    else
      st_ff <= nxt_st;
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_err_o = st_ff.err;
  assign wb_dat_o = st_ff.rdat;
  assign flash_wr_o = st_ff.fwr;
  assign flash_addr_o = st_ff.faddr;
  assign flash_data_o = st_ff.hold;
  assign cpu_stall_o = st_ff.busy;

  // launch sequence steps
  sequence s_launch;
    flash_wr_o && cpu_stall_o;
  endsequence

  AST_LAUNCH_STALLS: assert property (@(posedge ref_clk) // R9
    disable iff (!reset_n) $rose(cpu_stall_o) |-> flash_wr_o)
    else $error("stall rose without flash write");
  AST_WRITE_NEEDS_ENABLE: assert property (@(posedge ref_clk) // R1
    disable iff (!reset_n) flash_wr_o |->
    st_ff.ctrl[FWP_BIT_WRITE_EN] && st_ff.ctrl[FWP_BIT_WORD_SEL])
    else $error("flash write without enable and select");
  AST_KEY_BEFORE_START: assert property (@(posedge ref_clk) // R12
    disable iff (!reset_n) flash_wr_o |-> $past(st_ff.key) == KEY_OPEN)
    else $error("flash write without unlock key");
  AST_EVEN_ADDR: assert property (@(posedge ref_clk) // R4
    disable iff (!reset_n) flash_wr_o |-> !flash_addr_o[0])
    else $error("word written at odd address");
  AST_STALL_HOLDS: assert property (@(posedge ref_clk) // R9
    disable iff (!reset_n)
    s_launch |-> cpu_stall_o throughout (st_ff.cnt != 0)[*2])
    else $error("stall dropped early");
  AST_STALL_ENDS: assert property (@(posedge ref_clk) // R9
    disable iff (!reset_n)
    $fell(cpu_stall_o) |-> $past(st_ff.cnt) == 32'h00000001)
    else $error("stall ended before count expired");
  AST_KEY_ORDER: assert property (@(posedge ref_clk) // R7
    disable iff (!reset_n)
    st_ff.key == KEY_OPEN && $past(st_ff.key) != KEY_OPEN |->
    $past(st_ff.key) == KEY_GOT1)
    else $error("key opened out of order");
  AST_ACK_PULSE: assert property (@(posedge ref_clk)
    disable iff (!reset_n) wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");
  AST_START_BIT: assert property (@(posedge ref_clk) // R8
    disable iff (!reset_n) flash_wr_o |-> st_ff.ctrl[FWP_BIT_START])
    else $error("start bit not set at launch");
  // no second launch can sneak in while the array is still busy
  AST_NO_RELAUNCH: assert property (@(posedge ref_clk) // R9
    disable iff (!reset_n) flash_wr_o |-> !$past(cpu_stall_o))
    else $error("launch while a write was in progress");
  // the array reads address and data for the whole stall, so both freeze
  AST_DATA_STEADY: assert property (@(posedge ref_clk) // R4
    disable iff (!reset_n)
    cpu_stall_o && !flash_wr_o |-> $stable(flash_data_o))
    else $error("held word changed during the write");
  AST_ADDR_STEADY: assert property (@(posedge ref_clk) // R1
    disable iff (!reset_n)
    cpu_stall_o && !flash_wr_o |-> $stable(flash_addr_o))
    else $error("target address changed during the write");

endmodule

// ==== rtl/fwp_pkg.sv ====
package fwp_pkg;
  // register indices (byte address is four times the index)
  localparam logic [3:0] FWP_IDX_CTRL = 4'h0;
  localparam logic [3:0] FWP_IDX_KEY = 4'h1;
  localparam logic [3:0] FWP_IDX_PTR = 4'h2;
  localparam logic [3:0] FWP_IDX_LATCH = 4'h3;
  localparam logic [3:0] FWP_IDX_TBLWR = 4'h4;
  localparam logic [3:0] FWP_IDX_HOLD = 4'h5;
  localparam logic [3:0] FWP_IDX_STAT = 4'h6;
  // flash control register fields
  localparam int FWP_BIT_START = 1;
  localparam int FWP_BIT_WRITE_EN = 2;
  localparam int FWP_BIT_WORD_SEL = 5;
  // table write register fields
  localparam int FWP_BIT_POSTINC = 0;
  // unlock key values
  localparam logic [7:0] FWP_KEY_FIRST = 8'h55;
  localparam logic [7:0] FWP_KEY_SECOND = 8'haa;
  // widths and reset values
  localparam int FWP_PTR_W = 21;
  localparam logic [7:0] FWP_CTRL_RST = 8'h00;
  // word write time in ns, and derived cycle count at 4 ns
  localparam int FWP_CLK_PERIOD_NS = 4;
  localparam int FWP_WORD_WRITE_TIME_NS = 2800000;
  localparam int FWP_WORD_WRITE_CYC =
    FWP_WORD_WRITE_TIME_NS / FWP_CLK_PERIOD_NS;
  localparam logic [31:0] FWP_BAD_READ = 32'h00000000;
endpackage
